// [hdl/fpfs_pkg.sv]
package fpfs_pkg;
    // =====================================================
    // clock and pwm timebase
    localparam int CLK_HZ = 20_000_000;
    localparam int PWM_FREQ_HZ = 30;
    localparam int PWM_PERIOD_CLKS = CLK_HZ / PWM_FREQ_HZ;
    localparam int DUTY_W = 8;
    localparam int PWM_STEPS = 256;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] BLANK_STEPS = 8'h02;
    // =====================================================
    // sequencer interval lengths in pwm periods
    localparam logic [5:0] MISS_PERIODS = 6'h20;
    localparam logic [5:0] START_PERIODS = 6'h20;
    localparam logic [5:0] DIAG_PERIODS = 6'h03;
    // =====================================================
    // apb register map
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] CMD_RESET = 8'h00;
    // =====================================================
    // sequencer states, gray along the usual path
    typedef enum logic [2:0] {
        ST_SHDN = 3'h0,
        ST_START = 3'h1,
        ST_NORMAL = 3'h3,
        ST_DIAG = 3'h2,
        ST_RETRY = 3'h6,
        ST_FAULT = 3'h7
    } fpfs_state_t;
    // duty commands written by software
    typedef struct packed {
        logic [7:0] min_speed_shutdown_in;
        logic [7:0] temp_command_in;
    } fpfs_cmd_t;
endpackage

// [hdl/fpfs_timebase.sv]
`timescale 1ns/1ps
module fpfs_timebase
    import fpfs_pkg::*;
#(
    parameter int PERIOD_CLKS = PWM_PERIOD_CLKS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // timebase outputs
    output logic step_o,
    output logic period_o,
    output logic [DUTY_W-1:0] phase_o
);
    localparam int STEP_CLKS = (PERIOD_CLKS / PWM_STEPS > 0) ? PERIOD_CLKS / PWM_STEPS : 1;
    localparam logic [23:0] STEP_LAST = 24'(STEP_CLKS - 1);

    logic [23:0] div_r;

    // divider makes one step enable per duty step
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r <= '0;
            step_o <= 1'b0;
        end else if (div_r == STEP_LAST) begin
            div_r <= '0;
            step_o <= 1'b1;
        end else begin
            div_r <= div_r + 24'h000001;
            step_o <= 1'b0;
        end
    end

    // phase counter, period pulse on wrap
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_o <= '0;
            period_o <= 1'b0;
        end else begin
            period_o <= step_o && (phase_o == DUTY_FULL);
            if (step_o) begin
                phase_o <= phase_o + 8'h01;
            end
        end
    end
endmodule

// [hdl/fpfs_top.sv]
// Functional notes
// RULE1 - 32 pulseless periods give missing-pulse timeout
// RULE2 - start holds drive on 32 periods
// RULE3 - start interval after reset and shutdown exit
// RULE4 - timeout runs 3-period diagnostic then restart
// RULE5 - no pulse in both intervals means fault
// RULE6 - fault latches until shutdown or reset
// RULE7 - fault output is active low open drain
// RULE8 - full duty pulls fault, fan keeps running
// RULE9 - shutdown suspends all until release level
// RULE10 - shutdown fully resets sequencer and fault
// RULE11 - fault output released while in shutdown
// RULE12 - drive off in shutdown regardless of command
// RULE13 - all intervals counted in pwm periods; blanking window counted in duty steps
// RULE14 - temperature command maps linearly onto duty
// RULE15 - minimum speed command sets duty floor
// RULE16 - drive output active high turns switch on
// RULE17 - system may tie fault back to shutdown
// RULE18 - fan pulse restarts missing-pulse count
// RULE19 - pulses right after drive turn-on blanked
// RULE20 - duty follows larger of both commands
// RULE21 - failed first start retries start once
// RULE22 - comparators arrive as digital inputs
// RULE23 - pulse in start or diagnostic resumes normal
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fpfs_top
    import fpfs_pkg::*;
#(
    parameter int PERIOD_CLKS = PWM_PERIOD_CLKS
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // comparator and sense inputs
    input wire logic SHUTDOWN_LEVEL_I,
    input wire logic RELEASE_LEVEL_I,
    input wire logic FAN_PULSE_I,
    // fan drive and open-drain fault
    output logic FAN_DRIVE_OUT_O,
    output logic FAULT_N_O,
    output logic FAULT_OE_O
);
    // =====================================================
    // signals
    fpfs_state_t state_r, state_nxt;
    fpfs_cmd_t cmd_r;
    logic [5:0] cnt_r;
    logic [7:0] duty_r;
    logic [7:0] blank_r;
    logic [1:0] shdn_sync_r, rel_sync_r;
    logic [2:0] pulse_sync_r;
    logic shdn_lvl, rel_lvl, fan_edge, pulse_ok;
    logic step, period;
    logic [7:0] phase;
    logic drive_nxt, full_duty;

    // =====================================================
    // pwm timebase
    fpfs_timebase #(
        .PERIOD_CLKS(PERIOD_CLKS)
    ) u_timebase (
        .clk_i(CLK_SYS_I),
        .reset_n_i(RESET_N_I),
        .step_o(step),
        .period_o(period),
        .phase_o(phase)
    );

    // =====================================================
    // input synchronisers, third stage only for the edge
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            shdn_sync_r <= '0;
            rel_sync_r <= '0;
            pulse_sync_r <= '0;
        end else begin
            shdn_sync_r <= {shdn_sync_r[0], SHUTDOWN_LEVEL_I}; // RULE22
            rel_sync_r <= {rel_sync_r[0], RELEASE_LEVEL_I}; // RULE22
            pulse_sync_r <= {pulse_sync_r[1:0], FAN_PULSE_I}; // RULE22
        end
    end

    assign shdn_lvl = shdn_sync_r[1];
    assign rel_lvl = rel_sync_r[1];
    assign fan_edge = pulse_sync_r[1] && !pulse_sync_r[2];
    // pulses inside the blanking window are switching noise
    assign pulse_ok = fan_edge && (blank_r == 8'h00); // RULE19

    // =====================================================
    // blanking window after the drive turns on
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            blank_r <= 8'h00;
        end else if (drive_nxt && !FAN_DRIVE_OUT_O) begin
            blank_r <= BLANK_STEPS; // RULE19
        end else if (step && blank_r != 8'h00) begin
            blank_r <= blank_r - 8'h01;
        end
    end

    // =====================================================
    // duty latched once per pwm period from larger command
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            duty_r <= 8'h00;
        end else if (period) begin
            if (cmd_r.temp_command_in > cmd_r.min_speed_shutdown_in) begin
                duty_r <= cmd_r.temp_command_in; // RULE20 RULE14
            end else begin
                duty_r <= cmd_r.min_speed_shutdown_in; // RULE15
            end
        end
    end

    assign full_duty = (duty_r == DUTY_FULL);

    // =====================================================
    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SHDN: begin
                if (rel_lvl && !shdn_lvl) begin
                    state_nxt = ST_START; // RULE3 RULE9
                end
            end
            ST_START: begin
                if (pulse_ok) begin
                    state_nxt = ST_NORMAL; // RULE23
                end else if (period && cnt_r == START_PERIODS - 6'h01) begin
                    state_nxt = ST_RETRY; // RULE21
                end
            end
            ST_NORMAL: begin
                if (!pulse_ok && period && cnt_r == MISS_PERIODS - 6'h01) begin
                    state_nxt = ST_DIAG; // RULE1
                end
            end
            ST_DIAG: begin
                if (pulse_ok) begin
                    state_nxt = ST_NORMAL; // RULE23
                end else if (period && cnt_r == DIAG_PERIODS - 6'h01) begin
                    state_nxt = ST_RETRY; // RULE4
                end
            end
            ST_RETRY: begin
                if (pulse_ok) begin
                    state_nxt = ST_NORMAL; // RULE23
                end else if (period && cnt_r == START_PERIODS - 6'h01) begin
                    state_nxt = ST_FAULT; // RULE5
                end
            end
            ST_FAULT: begin
                state_nxt = ST_FAULT; // RULE6
            end
            default: begin
                state_nxt = ST_SHDN;
            end
        endcase
        // shutdown level overrides everything
        if (shdn_lvl) begin
            state_nxt = ST_SHDN; // RULE10 RULE9
        end
    end

    // sequencer state register
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= ST_SHDN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // period counter, cleared on entry and on each fan pulse
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cnt_r <= 6'h00;
        end else if (state_nxt != state_r || state_r == ST_SHDN) begin
            cnt_r <= 6'h00; // RULE10
        end else if (pulse_ok) begin
            cnt_r <= 6'h00; // RULE18
        end else if (period && state_r != ST_FAULT) begin
            cnt_r <= cnt_r + 6'h01; // RULE13
        end
    end

    // =====================================================
    // drive and fault outputs
    // decoded from the next state so the pins move with the state register
    always_comb begin
        case (state_nxt)
            ST_START, ST_DIAG, ST_RETRY: drive_nxt = 1'b1; // RULE2
            ST_NORMAL: drive_nxt = full_duty || (phase < duty_r); // RULE14
            default: drive_nxt = 1'b0; // RULE12 RULE5
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            FAN_DRIVE_OUT_O <= 1'b0;
            FAULT_OE_O <= 1'b0;
        end else begin
            FAN_DRIVE_OUT_O <= drive_nxt; // RULE16
            // pull low on latched fault or full duty, never in shutdown
            FAULT_OE_O <= (state_nxt == ST_FAULT)
                || (state_nxt != ST_SHDN && full_duty); // RULE7 RULE8 RULE11
        end
    end

    // the open-drain pin only ever pulls low
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            FAULT_N_O <= 1'b0;
        end else begin
            FAULT_N_O <= 1'b0; // RULE7
        end
    end

    // =====================================================
    // apb slave, zero wait state
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cmd_r <= '0;
        end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == ADDR_CMD) begin
            cmd_r <= fpfs_cmd_t'(PWDATA_I[15:0]);
        end
    end

    // read data and answer prepared in the setup cycle
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PRDATA_O <= 32'h00000000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I
                && PADDR_I != ADDR_CMD && PADDR_I != ADDR_STATUS;
            PRDATA_O <= 32'h00000000;
            if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
                if (PADDR_I == ADDR_CMD) begin
                    PRDATA_O <= {16'h0000, cmd_r};
                end else if (PADDR_I == ADDR_STATUS) begin
                    PRDATA_O <= {8'h00, duty_r, 2'h0, cnt_r, 3'h0,
                        FAULT_OE_O, FAN_DRIVE_OUT_O, state_r};
                end
            end
        end
    end

    // =====================================================
    // assertions
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);

    a_shdn_drive_off: assert property (state_r == ST_SHDN && state_nxt == ST_SHDN // RULE12
        |-> !FAN_DRIVE_OUT_O [*2])
        else $error("drive on in shutdown");
    a_shdn_fault_rel: assert property (state_r == ST_SHDN |=> !FAULT_OE_O || state_r != ST_SHDN) // RULE11
        else $error("fault pulled in shutdown");
    a_fault_latched: assert property (state_r == ST_FAULT && !shdn_lvl |=> state_r == ST_FAULT) // RULE6
        else $error("fault state left without shutdown");
    a_fault_pull_on: assert property (state_r == ST_FAULT && !shdn_lvl |=> FAULT_OE_O && !FAN_DRIVE_OUT_O) // RULE7
        else $error("fault not signalled");
    a_start_forced: assert property ($rose(state_r == ST_START) |-> FAN_DRIVE_OUT_O) // RULE2
        else $error("start interval not driving");
    a_miss_timeout: assert property (state_r == ST_NORMAL && period // RULE1
        && cnt_r == MISS_PERIODS - 6'h01 && !pulse_ok && !shdn_lvl |=> state_r == ST_DIAG)
        else $error("missing pulse timeout not taken");
    a_diag_length: assert property (state_r == ST_DIAG && period // RULE4
        && cnt_r == DIAG_PERIODS - 6'h01 && !pulse_ok && !shdn_lvl |=> state_r == ST_RETRY)
        else $error("diagnostic interval wrong length");
    a_retry_fault: assert property (state_r == ST_RETRY && period // RULE5
        && cnt_r == START_PERIODS - 6'h01 && !pulse_ok && !shdn_lvl
        |=> state_r == ST_FAULT ##1 !FAN_DRIVE_OUT_O)
        else $error("retry did not end in fault");
    a_pulse_restart: assert property (state_r == ST_NORMAL && pulse_ok |=> cnt_r == 6'h00) // RULE18
        else $error("pulse did not restart count");
    a_full_duty: assert property (state_r == ST_NORMAL && full_duty && !shdn_lvl |=> FAULT_OE_O) // RULE8
        else $error("full duty not flagged");
    a_shdn_reset: assert property (shdn_lvl |=> state_r == ST_SHDN && cnt_r == 6'h00) // RULE10
        else $error("shutdown did not reset sequencer");
    a_release_start: assert property (state_r == ST_SHDN && rel_lvl && !shdn_lvl // RULE3 RULE9
        |=> state_r == ST_START)
        else $error("release did not start the fan");
    a_start_retry: assert property (state_r == ST_START && period // RULE21
        && cnt_r == START_PERIODS - 6'h01 && !pulse_ok && !shdn_lvl |=> state_r == ST_RETRY)
        else $error("failed start did not retry");

    c_fault_reached: cover property (state_r == ST_RETRY ##1 state_r == ST_FAULT);
    c_diag_recover: cover property (state_r == ST_DIAG ##1 state_r == ST_NORMAL);
    c_fault_cleared: cover property (state_r == ST_FAULT ##1 state_r == ST_SHDN);
    c_full_duty: cover property (state_r == ST_NORMAL && full_duty);
    c_start_recover: cover property (state_r == ST_START ##1 state_r == ST_NORMAL);
endmodule

// [tb/fpfs_fan_model.sv]
`timescale 1ns/1ps
module fpfs_fan_model (
    // clock
    input wire logic clk_i,
    // fan state set by the bench
    input wire logic spin_i,
    // conditioned sense pulse
    output logic pulse_o
);
    // =====================================================
    // commutation pulses
    logic [6:0] cnt_r = 7'h00;
    // free-running pole counter, four clocks wide so the synchroniser sees it
    always_ff @(posedge clk_i) begin
        cnt_r <= cnt_r + 7'h01;
    end
    // a stalled fan gives no pulses and the sense line idles low
    assign pulse_o = spin_i && (cnt_r < 7'h04);
endmodule

// [tb/fpfs_top_tb.sv]
`timescale 1ns/1ps
module fpfs_top_tb;
    import fpfs_pkg::*;
    // =====================================================
    // bench signals
    localparam int PCLK = 256;
    localparam int LIMIT = 100000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic shdn = 1'b1;
    logic rel = 1'b0;
    logic spin = 1'b0;
    logic fan_pulse, drive, fault_n, fault_oe, pready, slverr_w, fault_pin, low_seen;
    logic [31:0] prdata, rdata;
    logic slverr;
    int cyc = 0;
    int waited;
    int err_count = 0;
    int num_checks = 0;
    logic [7:0] tv [4] = '{8'h40, 8'h10, 8'h00, 8'hFF};
    logic [7:0] mv [4] = '{8'h20, 8'h80, 8'h00, 8'h00};
    // =====================================================
    // design and fan
    fpfs_top #(.PERIOD_CLKS(PCLK)) dut_u (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(slverr_w),
        .SHUTDOWN_LEVEL_I(shdn), .RELEASE_LEVEL_I(rel), .FAN_PULSE_I(fan_pulse),
        .FAN_DRIVE_OUT_O(drive), .FAULT_N_O(fault_n), .FAULT_OE_O(fault_oe));
    fpfs_fan_model fan_u (.clk_i(clk), .spin_i(spin), .pulse_o(fan_pulse));
    // open-drain pin with pull-up
    assign fault_pin = fault_oe ? fault_n : 1'b1;
    // =====================================================
    // clock, cycle count, drive monitor, timeout
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (drive !== 1'b1) low_seen <= 1'b1;
    end
    always @(posedge clk) begin
        if (cyc == LIMIT) begin
            err_count++;
            print_verdict();
        end
    end
    // =====================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, released only after pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait states end only at pready or at the bench timeout
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        slverr = slverr_w;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // poll status until the sequencer reaches a state
    task automatic wait_state(input logic [2:0] s, input int lim);
        int t0;
        t0 = cyc;
        do apb(1'b0, ADDR_STATUS, 32'h0);
        while (rdata[2:0] !== s && cyc - t0 < lim);
        waited = cyc - t0;
        chk("state", {29'h0, s}, {29'h0, rdata[2:0]});
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // =====================================================
    // test sequence
    initial begin
        int hi;
        int exp_hi;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wait_state(ST_SHDN, 8);
        chk("drive_rst", 32'h0, {31'h0, drive});
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, slverr});
        chk("unmapped_data", 32'h0, rdata);
        apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        apb(1'b0, ADDR_CMD, 32'h0);
        chk("cmd_rst", 32'h0, rdata);
        // full command while held in shutdown
        apb(1'b1, ADDR_CMD, 32'h000000FF);
        repeat (4 * PCLK) @(posedge clk);
        chk("shdn_drive", 32'h0, {31'h0, drive});
        chk("shdn_fault", 32'h1, {31'h0, fault_pin});
        wait_state(ST_SHDN, 8);
        // release with a stalled fan: start, retry, latched fault
        apb(1'b1, ADDR_CMD, 32'h00002040);
        shdn <= 1'b0;
        rel <= 1'b1;
        wait_state(ST_START, 30);
        low_seen = 1'b0;
        wait_state(ST_RETRY, 40 * PCLK);
        hi = (waited >= 31 * PCLK - 8 && waited <= 32 * PCLK + 20);
        chk("start_len", 32'h1, {31'h0, hi[0]});
        chk("start_on", 32'h0, {31'h0, low_seen});
        wait_state(ST_FAULT, 34 * PCLK);
        repeat (4 * PCLK) @(posedge clk);
        wait_state(ST_FAULT, 8);
        chk("fault_drive", 32'h0, {31'h0, drive});
        chk("fault_pin", 32'h0, {31'h0, fault_pin});
        // shutdown clears the fault, restart with a spinning fan
        shdn <= !fault_pin;
        rel <= 1'b0;
        wait_state(ST_SHDN, 30);
        chk("clr_fault", 32'h1, {31'h0, fault_pin});
        shdn <= 1'b0;
        rel <= 1'b1;
        wait_state(ST_START, 30);
        spin <= 1'b1;
        wait_state(ST_NORMAL, PCLK);
        // duty from the larger command, full scale flags the fault pin
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CMD, {16'h0, mv[i], tv[i]});
            repeat (2 * PCLK) @(posedge clk);
            hi = 0;
            repeat (PCLK) begin
                @(posedge clk);
                hi += (drive === 1'b1);
            end
            exp_hi = (tv[i] > mv[i]) ? int'(tv[i]) : int'(mv[i]);
            if (exp_hi == int'(DUTY_FULL)) exp_hi = PCLK;
            chk("duty", exp_hi, hi);
            chk("full_flag", {31'h0, tv[i] != 8'hFF}, {31'h0, fault_pin});
        end
        wait_state(ST_NORMAL, 8);
        apb(1'b1, ADDR_CMD, 32'h00002040);
        // a turning fan keeps the missing-pulse count from expiring
        repeat (40 * PCLK) @(posedge clk);
        wait_state(ST_NORMAL, 8);
        // stall in normal: timeout, diagnostic, retry, recovery
        spin <= 1'b0;
        wait_state(ST_DIAG, 34 * PCLK);
        hi = (waited >= 30 * PCLK && waited <= 32 * PCLK + 20);
        chk("miss_len", 32'h1, {31'h0, hi[0]});
        chk("diag_drive", 32'h1, {31'h0, drive});
        wait_state(ST_RETRY, 4 * PCLK);
        hi = (waited >= 3 * PCLK - 12 && waited <= 3 * PCLK + 12);
        chk("diag_len", 32'h1, {31'h0, hi[0]});
        spin <= 1'b1;
        wait_state(ST_NORMAL, PCLK);
        print_verdict();
    end
endmodule
